// ==== logic/dmcwd_pkg.sv ====
package dmcwd_pkg;

    // apb register byte offsets
    localparam logic [7:0] DMCWD_CMD_OFS    = 8'h00;
    localparam logic [7:0] DMCWD_FEX_OFS    = 8'h04;
    localparam logic [7:0] DMCWD_CFG_OFS    = 8'h08;
    localparam logic [7:0] DMCWD_USED_OFS   = 8'h0c;
    localparam logic [7:0] DMCWD_STAT_OFS   = 8'h10;
    localparam logic [7:0] DMCWD_IRQS_OFS   = 8'h14;
    localparam logic [7:0] DMCWD_IRQM_OFS   = 8'h18;

    // command word bit positions
    localparam int DMCWD_B_ON    = 0;
    localparam int DMCWD_B_COAST = 1;
    localparam int DMCWD_B_ESTOP = 2;
    localparam int DMCWD_B_RUN   = 3;
    localparam int DMCWD_B_ROUT  = 4;
    localparam int DMCWD_B_RHOLD = 5;
    localparam int DMCWD_B_RIN   = 6;

    // command word reset: both stop bits and the three ramp bits (4 to 6) at 1, switch-on and run off
    localparam logic [15:0] DMCWD_CMD_RST = 16'h0076;

    // config register fields
    localparam int DMCWD_CFG_MODE = 0;
    localparam int DMCWD_CFG_OFF  = 1;
    localparam int DMCWD_CFG_EST  = 3;
    localparam int DMCWD_CFG_RUN  = 5;
    localparam int DMCWD_CFG_W    = 7;
    localparam logic [6:0] DMCWD_CFG_RST = 7'h00;

    // status word fields
    localparam int DMCWD_S_READY_TO_RUN_STATE = 0;
    localparam int DMCWD_S_READY_FOR_REFERENCE_STATE = 1;
    localparam int DMCWD_S_INHIB  = 2;
    localparam int DMCWD_S_STOP   = 3;
    localparam int DMCWD_S_STATE  = 4;

    // interrupt bits
    localparam int DMCWD_IRQ_W     = 4;
    localparam int DMCWD_I_STATE   = 0;
    localparam int DMCWD_I_COAST   = 1;
    localparam int DMCWD_I_ESTOP   = 2;
    localparam int DMCWD_I_FEXERR  = 3;

    // coast stop retard angle in degrees
    localparam logic [7:0] DMCWD_COAST_DEG = 8'h96;

    // exciter state codes
    localparam logic [2:0] DMCWD_FEX_ABSENT = 3'h0;
    localparam logic [2:0] DMCWD_FEX_GOOD   = 3'h1;

    typedef enum logic [2:0] {
        DMCWD_OFF     = 3'b000,
        DMCWD_RDY_RUN = 3'b001,
        DMCWD_RDY_REF = 3'b010,
        DMCWD_RUN_STP = 3'b011,
        DMCWD_OFF_STP = 3'b100,
        DMCWD_COAST   = 3'b101,
        DMCWD_ESTOP   = 3'b110,
        DMCWD_INHIBIT = 3'b111
    } dmcwd_state_t;

    typedef enum logic [1:0] {
        DMCWD_SM_NONE = 2'b00,
        DMCWD_SM_OFF  = 2'b01,
        DMCWD_SM_RUN  = 2'b10,
        DMCWD_SM_EST  = 2'b11
    } dmcwd_stop_src_t;

    typedef struct packed {
        dmcwd_state_t    st;
        logic [15:0]     cmd;
        logic [15:0]     used;
        logic [6:0]      cfg;
        logic [2:0]      fex_s1;
        logic [2:0]      fex_s2;
        logic [2:0]      fex_prev;
        logic            cur_s1;
        logic            cur_s2;
        logic            spd_s1;
        logic            spd_s2;
        logic [3:0]      irq_sts;
        logic [3:0]      irq_msk;
        logic [31:0]     rdata;
        logic            contactor;
        logic            fans;
        logic            fire_rel;
        logic            fire_blk;
        logic            retard;
        dmcwd_stop_src_t stop_src;
        logic [1:0]      stop_mode;
    } dmcwd_regs_t;

endpackage

// ==== logic/dmcwd_decoder.sv ====
// Operation
// - the second motor exciter state reads as a code 0 to 7: absent, good, link fault, selftest fault, not ready, undercurrent, overcurrent, config error.
// - switch-on at 1 in plain switch-on mode commands ready-to-run, closes the contactors and starts exciter and fans.
// - switch-on at 1 in switch-on-with-run mode forces the ready-to-run flag of the state word to 1.
// - coast stop at 0 enters switch-on-inhibit by coasting and retards firing to 150 degrees at once.
// - during a coast stop, zero armature current blocks firing, opens contactors and stops exciter and fans.
// - coast stop wins over emergency stop and switch-on when asserted together.
// - emergency stop at 0 enters switch-on-inhibit via the emergency stop mode; at 1 nothing happens.
// - emergency stop wins over switch-on.
// - run at 1 moves to ready-for-reference, releases firing and runs at the speed reference.
// - run at 0 returns to ready-to-run via the run stop mode.
// - bit 4 at 0 forces the ramp output to zero.
// - bit 5 at 0 freezes the ramp.
// - bit 6 at 0 forces the ramp input to zero.
// - the command word and config are writable while the in-use word is read-only.
//
// The placing of the registers and the APB register port were left to the implementer.
module dmcwd_decoder
    import dmcwd_pkg::*;
(
    input  wire logic        clock_in,
    input  wire logic        nrst_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic             pready_out,
    output logic [31:0]      prdata_out,
    output logic             pslverr_out,
    input  wire logic [2:0]  exciter_code_in,
    input  wire logic        armature_zero_in,
    input  wire logic        speed_zero_in,
    output logic             contactor_close_out,
    output logic             exciter_fans_on_out,
    output logic             firing_release_out,
    output logic             firing_block_out,
    output logic             firing_retard_out,
    output logic [7:0]       firing_angle_out,
    output logic [1:0]       stop_mode_out,
    output logic             stopping_out,
    output logic             ramp_output_clear_out,
    output logic             ramp_freeze_out,
    output logic             ramp_input_clear_out,
    output logic [15:0]      main_drive_state_word_out,
    output logic             irq_out
);

    ////////////////////////////////////////////////////////////////////////
    // state

    dmcwd_regs_t r_q;
    dmcwd_regs_t r_d;

    logic        setup;
    logic        access;
    logic        wr;
    logic        mapped;
    logic        ro_hit;
    logic        switch_on_cmd;
    logic        coast_stop_n;
    logic        emergency_stop_n;
    logic        run_cmd;
    logic        onrun_mode;
    logic        ready_to_run_state;
    logic        ready_for_reference_state;
    logic        switch_on_inhibit_state;
    logic [15:0] state_word;
    logic [3:0]  events;

    ////////////////////////////////////////////////////////////////////////
    // decode helpers

    assign setup  = psel_in && !penable_in;
    assign access = psel_in && penable_in;
    assign wr     = access && pwrite_in;

    always_comb begin
        unique case (paddr_in)
            DMCWD_CMD_OFS,
            DMCWD_CFG_OFS,
            DMCWD_IRQS_OFS,
            DMCWD_IRQM_OFS: begin
                mapped = 1'b1;
                ro_hit = 1'b0;
            end
            DMCWD_FEX_OFS,
            DMCWD_USED_OFS,
            DMCWD_STAT_OFS: begin
                mapped = 1'b1;
                ro_hit = 1'b1;
            end
            default: begin
                mapped = 1'b0;
                ro_hit = 1'b0;
            end
        endcase
    end

    // decisions use the in-use word, so one write applies atomically
    assign switch_on_cmd    = r_q.used[DMCWD_B_ON];
    assign coast_stop_n     = r_q.used[DMCWD_B_COAST];
    assign emergency_stop_n = r_q.used[DMCWD_B_ESTOP];
    assign run_cmd          = r_q.used[DMCWD_B_RUN];
    assign onrun_mode       = r_q.cfg[DMCWD_CFG_MODE];

    ////////////////////////////////////////////////////////////////////////
    // state word

    assign ready_for_reference_state = (r_q.st == DMCWD_RDY_REF);
    assign switch_on_inhibit_state   = (r_q.st == DMCWD_INHIBIT);

    always_comb begin
        ready_to_run_state = (r_q.st == DMCWD_RDY_RUN)
                          || (r_q.st == DMCWD_RDY_REF)
                          || (r_q.st == DMCWD_RUN_STP);
        if (switch_on_cmd && onrun_mode && coast_stop_n && emergency_stop_n) begin
            ready_to_run_state = 1'b1;
        end
    end

    always_comb begin
        state_word = 16'h0000;
        state_word[DMCWD_S_READY_TO_RUN_STATE] = ready_to_run_state;
        state_word[DMCWD_S_READY_FOR_REFERENCE_STATE] = ready_for_reference_state;
        state_word[DMCWD_S_INHIB]  = switch_on_inhibit_state;
        state_word[DMCWD_S_STOP]   = (r_q.stop_src != DMCWD_SM_NONE);
        state_word[DMCWD_S_STATE +: 3] = r_q.st;
    end

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        r_d    = r_q;
        events = 4'h0;

        // pins cross in through two flops each
        r_d.fex_s1 = exciter_code_in;
        r_d.fex_s2 = r_q.fex_s1;
        r_d.cur_s1 = armature_zero_in;
        r_d.cur_s2 = r_q.cur_s1;
        r_d.spd_s1 = speed_zero_in;
        r_d.spd_s2 = r_q.spd_s1;
        // fault edge compares settled codes only, never the first flop
        r_d.fex_prev = r_q.fex_s2;

        // in-use word follows the written word one cycle later
        r_d.used = r_q.cmd;

        // command sequencing
        unique case (r_q.st)
            DMCWD_OFF,
            DMCWD_RDY_RUN,
            DMCWD_RDY_REF,
            DMCWD_RUN_STP,
            DMCWD_OFF_STP: begin
                if (!coast_stop_n) begin
                    r_d.st = DMCWD_COAST;
                end else if (!emergency_stop_n) begin
                    r_d.st = DMCWD_ESTOP;
                end else begin
                    unique case (r_q.st)
                        DMCWD_OFF: begin
                            if (switch_on_cmd) begin
                                r_d.st = DMCWD_RDY_RUN;
                            end
                        end
                        DMCWD_RDY_RUN: begin
                            if (!switch_on_cmd) begin
                                r_d.st = DMCWD_OFF_STP;
                            end else if (run_cmd) begin
                                r_d.st = DMCWD_RDY_REF;
                            end
                        end
                        DMCWD_RDY_REF: begin
                            if (!switch_on_cmd) begin
                                r_d.st = DMCWD_OFF_STP;
                            end else if (!run_cmd) begin
                                r_d.st = DMCWD_RUN_STP;
                            end
                        end
                        DMCWD_RUN_STP: begin
                            if (!switch_on_cmd) begin
                                r_d.st = DMCWD_OFF_STP;
                            end else if (run_cmd) begin
                                r_d.st = DMCWD_RDY_REF;
                            end else if (r_q.spd_s2) begin
                                r_d.st = DMCWD_RDY_RUN;
                            end
                        end
                        default: begin
                            // off stop ends at standstill
                            if (r_q.spd_s2) begin
                                r_d.st = DMCWD_OFF;
                            end
                        end
                    endcase
                end
            end
            DMCWD_COAST: begin
                if (r_q.cur_s2) begin
                    r_d.st = DMCWD_INHIBIT;
                end
            end
            DMCWD_ESTOP: begin
                if (!coast_stop_n) begin
                    r_d.st = DMCWD_COAST;
                end else if (r_q.spd_s2) begin
                    r_d.st = DMCWD_INHIBIT;
                end
            end
            DMCWD_INHIBIT: begin
                // re-arm only once switch-on was dropped and stops released
                if (!switch_on_cmd && coast_stop_n && emergency_stop_n) begin
                    r_d.st = DMCWD_OFF;
                end
            end
        endcase

        // drive outputs per next state
        r_d.contactor = 1'b0;
        r_d.fire_rel  = 1'b0;
        r_d.fire_blk  = 1'b1;
        r_d.retard    = 1'b0;
        r_d.stop_src  = DMCWD_SM_NONE;
        r_d.stop_mode = 2'b00;
        unique case (r_d.st)
            DMCWD_RDY_RUN: begin
                // switch-on-with-run defers closing until run
                r_d.contactor = !onrun_mode;
            end
            DMCWD_RDY_REF: begin
                r_d.contactor = 1'b1;
                r_d.fire_rel  = 1'b1;
                r_d.fire_blk  = 1'b0;
            end
            DMCWD_RUN_STP: begin
                r_d.contactor = 1'b1;
                r_d.fire_blk  = 1'b0;
                r_d.stop_src  = DMCWD_SM_RUN;
                r_d.stop_mode = r_q.cfg[DMCWD_CFG_RUN +: 2];
            end
            DMCWD_OFF_STP: begin
                r_d.contactor = 1'b1;
                r_d.fire_blk  = 1'b0;
                r_d.stop_src  = DMCWD_SM_OFF;
                r_d.stop_mode = r_q.cfg[DMCWD_CFG_OFF +: 2];
            end
            DMCWD_COAST: begin
                // contactors keep their last value until current has died away
                r_d.contactor = r_q.contactor;
                r_d.fire_blk  = 1'b0;
                r_d.retard    = 1'b1;
            end
            DMCWD_ESTOP: begin
                r_d.contactor = 1'b1;
                r_d.fire_blk  = 1'b0;
                r_d.stop_src  = DMCWD_SM_EST;
                r_d.stop_mode = r_q.cfg[DMCWD_CFG_EST +: 2];
            end
            default: begin
                // off and inhibit: pulses blocked, contactors open
                r_d.contactor = 1'b0;
            end
        endcase
        r_d.fans = r_d.contactor;

        // events
        events[DMCWD_I_STATE] = (r_d.st != r_q.st);
        events[DMCWD_I_COAST] = (r_d.st == DMCWD_COAST) && (r_q.st != DMCWD_COAST);
        events[DMCWD_I_ESTOP] = (r_d.st == DMCWD_ESTOP) && (r_q.st != DMCWD_ESTOP);
        events[DMCWD_I_FEXERR] = (r_q.fex_s2 != r_q.fex_prev)
                              && (r_q.fex_s2 != DMCWD_FEX_ABSENT)
                              && (r_q.fex_s2 != DMCWD_FEX_GOOD);

        // apb writes; read-only words ignore them
        if (wr) begin
            unique case (paddr_in)
                DMCWD_CMD_OFS: begin
                    r_d.cmd = pwdata_in[15:0];
                end
                DMCWD_CFG_OFS: begin
                    r_d.cfg = pwdata_in[DMCWD_CFG_W-1:0];
                end
                DMCWD_IRQM_OFS: begin
                    r_d.irq_msk = pwdata_in[DMCWD_IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // sticky status: a new event beats the write-one clear
        r_d.irq_sts = r_q.irq_sts;
        if (wr && (paddr_in == DMCWD_IRQS_OFS)) begin
            r_d.irq_sts = r_q.irq_sts & ~pwdata_in[DMCWD_IRQ_W-1:0];
        end
        r_d.irq_sts = r_d.irq_sts | events;

        // read data captured in setup so access answers from a flop
        r_d.rdata = 32'h0000_0000;
        if (setup && !pwrite_in) begin
            unique case (paddr_in)
                DMCWD_CMD_OFS: begin
                    r_d.rdata[15:0] = r_q.cmd;
                end
                DMCWD_FEX_OFS: begin
                    r_d.rdata[2:0] = r_q.fex_s2;
                end
                DMCWD_CFG_OFS: begin
                    r_d.rdata[DMCWD_CFG_W-1:0] = r_q.cfg;
                end
                DMCWD_USED_OFS: begin
                    r_d.rdata[15:0] = r_q.used;
                end
                DMCWD_STAT_OFS: begin
                    r_d.rdata[15:0] = state_word;
                end
                DMCWD_IRQS_OFS: begin
                    r_d.rdata[DMCWD_IRQ_W-1:0] = r_q.irq_sts;
                end
                DMCWD_IRQM_OFS: begin
                    r_d.rdata[DMCWD_IRQ_W-1:0] = r_q.irq_msk;
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            r_q           <= '0;
            r_q.st        <= DMCWD_OFF;
            r_q.cmd       <= DMCWD_CMD_RST;
            r_q.used      <= DMCWD_CMD_RST;
            r_q.cfg       <= DMCWD_CFG_RST;
            r_q.fire_blk  <= 1'b1;
            r_q.stop_src  <= DMCWD_SM_NONE;
        end else begin
            r_q <= r_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    // zero wait states; any unmapped access or a read-only write flags an error
    assign pready_out  = 1'b1;
    assign prdata_out  = r_q.rdata;
    assign pslverr_out = access && (!mapped || (pwrite_in && ro_hit));

    assign contactor_close_out = r_q.contactor;
    assign exciter_fans_on_out = r_q.fans;
    assign firing_release_out  = r_q.fire_rel;
    assign firing_block_out    = r_q.fire_blk;
    assign firing_retard_out   = r_q.retard;
    assign firing_angle_out    = r_q.retard ? DMCWD_COAST_DEG : 8'h00;
    assign stop_mode_out       = r_q.stop_mode;
    assign stopping_out        = (r_q.stop_src != DMCWD_SM_NONE);

    // ramp controls act on the word in use; low bit means act
    assign ramp_output_clear_out = !r_q.used[DMCWD_B_ROUT];
    assign ramp_freeze_out       = !r_q.used[DMCWD_B_RHOLD];
    assign ramp_input_clear_out  = !r_q.used[DMCWD_B_RIN];

    assign main_drive_state_word_out = state_word;

    assign irq_out = |(r_q.irq_sts & r_q.irq_msk);

endmodule

// ==== verification/dmcwd_decoder_assertions.sv ====
module dmcwd_decoder_assertions
    import dmcwd_pkg::*;
(
    input wire logic        clock_in,
    input wire logic        nrst_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [7:0]  paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic        pslverr_out,
    input wire logic        contactor_close_out,
    input wire logic        exciter_fans_on_out,
    input wire logic        firing_release_out,
    input wire logic        firing_block_out,
    input wire logic        firing_retard_out,
    input wire logic [7:0]  firing_angle_out,
    input wire logic        stopping_out,
    input wire logic        ramp_output_clear_out,
    input wire logic        ramp_freeze_out,
    input wire logic        ramp_input_clear_out,
    input wire logic [15:0] main_drive_state_word_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!nrst_in);

    logic [2:0] st;
    assign st = main_drive_state_word_out[6:4];

    ////////////////////////////////////////////////////////////////////////////////
    sequence s_cmd_wr;
        psel_in && penable_in && pwrite_in && paddr_in == DMCWD_CMD_OFS;
    endsequence

    // word lands in the in-use copy two edges on, state one edge later
    chk_ramp_out_clr: assert property (s_cmd_wr ##0 !pwdata_in[4] |-> ##2 ramp_output_clear_out)
        else $error("ramp output clear missing");
    chk_ramp_hold: assert property (s_cmd_wr ##0 !pwdata_in[5] |-> ##2 ramp_freeze_out)
        else $error("ramp freeze missing");
    chk_ramp_in_clr: assert property (s_cmd_wr ##0 !pwdata_in[6] |-> ##2 ramp_input_clear_out)
        else $error("ramp input clear missing");
    chk_coast_entry: assert property (s_cmd_wr ##0 (!pwdata_in[1] && st != 3'h7)
        |-> ##3 (st == 3'h5 && firing_retard_out))
        else $error("coast stop not entered");
    chk_estop_entry: assert property (s_cmd_wr ##0 (pwdata_in[1] && !pwdata_in[2]
        && st inside {3'h1, 3'h2}) |-> ##3 (st == 3'h6 && stopping_out))
        else $error("emergency stop not entered");
    chk_off_entry: assert property (s_cmd_wr ##0 (pwdata_in[2:0] == 3'h6 && st == 3'h1)
        |-> ##3 (st == 3'h4 && stopping_out))
        else $error("off stop not entered");
    chk_run_entry: assert property (s_cmd_wr ##0 (pwdata_in[3:0] == 4'hf && st == 3'h1)
        |-> ##3 st == 3'h2)
        else $error("run state not entered");
    chk_angle_value: assert property (firing_angle_out
        == ((st == 3'h5) ? DMCWD_COAST_DEG : 8'h00))
        else $error("firing angle wrong");
    chk_fans_follow: assert property (exciter_fans_on_out == contactor_close_out)
        else $error("fans differ from contactor");
    chk_inhibit_open: assert property (st == 3'h7
        |-> firing_block_out && !contactor_close_out && !firing_retard_out)
        else $error("inhibit leaves power on");
    chk_release_ref: assert property (firing_release_out == (st == 3'h2))
        else $error("firing release outside run");
    chk_ro_refused: assert property (psel_in && penable_in && pwrite_in
        && paddr_in == DMCWD_USED_OFS |-> pslverr_out)
        else $error("in-use word write accepted");
endmodule

bind dmcwd_decoder dmcwd_decoder_assertions u_chk (.*);

// ==== verification/dmcwd_plant.sv ====
module dmcwd_plant
(
    input  wire logic       clock_in,
    input  wire logic       nrst_in,
    input  wire logic       firing_release_in,
    input  wire logic [2:0] code_in,
    output logic            armature_zero_out,
    output logic            speed_zero_out,
    output logic [2:0]      exciter_code_out
);
    timeunit 1ns;
    timeprecision 1ns;

    // cycles since firing was withdrawn; current decays before speed does
    logic [4:0] idle_q = 5'h10;

    always @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            idle_q <= 5'h10;
        end else if (firing_release_in) begin
            idle_q <= 5'h00;
        end else if (idle_q != 5'h1f) begin
            idle_q <= idle_q + 5'h01;
        end
    end

    assign armature_zero_out = idle_q >= 5'h08;
    assign speed_zero_out    = idle_q >= 5'h10;
    assign exciter_code_out  = code_in;
endmodule

// ==== verification/dmcwd_decoder_tb.sv ====
module dmcwd_decoder_tb
    import dmcwd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clock_in = 1'b0, nrst_in = 1'b0, psel_in = 1'b0, penable_in = 1'b0;
    logic        pwrite_in = 1'b0, armature_zero_in, speed_zero_in, pready_out, pslverr_out;
    logic        contactor_close_out, exciter_fans_on_out, firing_release_out, irq_out;
    logic        firing_block_out, firing_retard_out, stopping_out, re;
    logic        ramp_output_clear_out, ramp_freeze_out, ramp_input_clear_out;
    logic [7:0]  paddr_in = 8'h00, firing_angle_out;
    logic [31:0] pwdata_in = 32'h0, prdata_out, rq;
    logic [2:0]  exciter_code_in, code_sel = 3'h1;
    logic [1:0]  stop_mode_out;
    logic [15:0] main_drive_state_word_out;
    logic [2:0]  st;
    int          mismatches = 0, compares = 0;

    assign st = main_drive_state_word_out[6:4];

    dmcwd_decoder uut (.*);
    dmcwd_plant plant (.clock_in(clock_in), .nrst_in(nrst_in),
        .firing_release_in(firing_release_out), .code_in(code_sel),
        .armature_zero_out(armature_zero_in), .speed_zero_out(speed_zero_in),
        .exciter_code_out(exciter_code_in));

    always #25 clock_in = ~clock_in;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // one apb transfer; read data and error land in rq and re
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clock_in);
        penable_in <= 1'b1;
        @(posedge clock_in);
        while (pready_out !== 1'b1) @(posedge clock_in);
        rq = prdata_out;
        re = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask

    task automatic cmd(input logic [31:0] d, input int n);
        apb(1'b1, DMCWD_CMD_OFS, d);
        repeat (n) @(posedge clock_in);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clock_in);
        mismatches++;
        tally_and_finish();
    end

    initial begin
        repeat (6) @(posedge clock_in);
        nrst_in <= 1'b1;
        apb(1'b0, DMCWD_CMD_OFS, 32'h0);
        check(rq, 32'h76);
        apb(1'b0, DMCWD_USED_OFS, 32'h0);
        check(rq, 32'h76);
        check(main_drive_state_word_out, 32'h0);
        check(firing_block_out, 32'h1);
        apb(1'b0, 8'h1c, 32'h0);
        check({re, rq[30:0]}, 32'h80000000);
        apb(1'b1, DMCWD_USED_OFS, 32'h0);
        check(re, 32'h1);
        apb(1'b1, DMCWD_CFG_OFS, 32'h4e);
        apb(1'b0, DMCWD_CFG_OFS, 32'h0);
        check(rq, 32'h4e);
        $display("test reset and access done");
        // stop bits stay high in normal use
        cmd(32'h77, 2);
        check(main_drive_state_word_out, 32'h11);
        check({contactor_close_out, exciter_fans_on_out}, 32'h3);
        for (int b = 4; b < 7; b++) begin
            cmd(32'h77 & ~(32'h1 << b), 2);
            check({ramp_input_clear_out, ramp_freeze_out, ramp_output_clear_out},
                32'h1 << (b - 4));
        end
        cmd(32'h7f, 2);
        check({st, firing_release_out, stopping_out}, 32'h0a);
        cmd(32'h77, 2);
        check({st, stopping_out, stop_mode_out}, 32'h1e);
        repeat (26) @(posedge clock_in);
        #1;
        check(st, 32'h1);
        cmd(32'h76, 2);
        check({st, stop_mode_out}, 32'h13);
        repeat (4) @(posedge clock_in);
        #1;
        check({st, contactor_close_out}, 32'h0);
        $display("test run and off done");
        apb(1'b1, DMCWD_IRQS_OFS, 32'hf);
        apb(1'b1, DMCWD_IRQM_OFS, 32'h4);
        cmd(32'h77, 4);
        check(irq_out, 32'h0);
        cmd(32'h73, 2);
        check({st, stop_mode_out, stopping_out}, 32'h33);
        repeat (4) @(posedge clock_in);
        #1;
        check({st, firing_block_out, irq_out}, 32'h1f);
        apb(1'b0, DMCWD_IRQS_OFS, 32'h0);
        check(rq, 32'h5);
        apb(1'b1, DMCWD_IRQS_OFS, 32'h4);
        apb(1'b0, DMCWD_IRQS_OFS, 32'h0);
        check({rq[3:0], irq_out}, 32'h2);
        cmd(32'h76, 4);
        check(st, 32'h0);
        $display("test emergency stop done");
        cmd(32'h77, 2);
        cmd(32'h7f, 4);
        // coast and emergency stop and switch-on together
        cmd(32'h79, 2);
        check({st, firing_retard_out, contactor_close_out}, 32'h17);
        check(firing_angle_out, DMCWD_COAST_DEG);
        repeat (16) @(posedge clock_in);
        #1;
        check({st, firing_block_out, contactor_close_out}, 32'h1e);
        check(exciter_fans_on_out, 32'h0);
        apb(1'b0, DMCWD_IRQS_OFS, 32'h0);
        check(rq[1], 32'h1);
        cmd(32'h76, 4);
        $display("test coast stop done");
        apb(1'b1, DMCWD_CFG_OFS, 32'h4f);
        cmd(32'h77, 1);
        check({main_drive_state_word_out[0], st}, 32'h8);
        @(posedge clock_in);
        #1;
        check({main_drive_state_word_out[0], contactor_close_out}, 32'h2);
        cmd(32'h7f, 2);
        check({st, contactor_close_out}, 32'h5);
        cmd(32'h76, 30);
        $display("test switch-on-with-run done");
        for (int i = 0; i < 8; i++) begin
            @(posedge clock_in);
            code_sel <= 3'(i);
            repeat (4) @(posedge clock_in);
            apb(1'b0, DMCWD_FEX_OFS, 32'h0);
            check(rq, 32'(i));
        end
        apb(1'b0, DMCWD_IRQS_OFS, 32'h0);
        check(rq[3], 32'h1);
        $display("test exciter codes done");
        tally_and_finish();
    end
endmodule
